/* File: rtl/mscl_regs.vh */
// Constants for the monitor serial command link
`ifndef MSCL_REGS_VH
`define MSCL_REGS_VH
`define MSCL_DIV_HIGH 11'h400
`define MSCL_DIV_LOW 11'h200
`define MSCL_BREAK_BITS 4'hA
`define MSCL_PRE_GAP_BITS 4'h2
`define MSCL_END_WAIT_BITS 4'hB
`define MSCL_SEC_BYTES 4'h8
`define MSCL_SEC_BASE 16'hFFF6
`define MSCL_SEC_FLAG_ADDR 16'h0060
`define MSCL_SEC_FLAG_BIT 6
`define MSCL_SP_PLUS 16'h0001
`define MSCL_OP_READ 8'h4A
`define MSCL_OP_WRITE 8'h49
`define MSCL_OP_INDEXED_READ_CMD 8'h1A
`define MSCL_OP_INDEXED_WRITE_CMD 8'h19
`define MSCL_OP_STACK_POINTER_READ_CMD 8'h0C
`define MSCL_OP_RUN 8'h28
`endif

/* File: rtl/mscl_link.v */
// Monitor mode serial command link, device end
// Contract
// - Break is ten low bits; device idles two bits high, then echoes a break
// - Test-voltage entry: baud pin high gives divisor 1024, low gives 512
// - Normal-supply entry fixes the divisor at 1024
// - 2.4576 MHz internal rate gives 2400 bit/s at divisor 1024, 4800 bit/s at 512
// - Every security and command byte received is echoed; bytes arriving during the end wait are not
// - Eleven-bit wait ends each command; a break there is echoed, then the last command runs again
// - Two-bit gap before each echo and before returned read data
// - Read data follows the echo of the last command byte
// - Six commands: read, write, indexed read/write, stack read, run
// - Indexed commands step the address through all 64 Kbytes
// - Run command pulls index-high and returns from interrupt
// - Stack read returns stack pointer plus one
// - After power-on, eight security bytes compared with FFF6..FFFD
// - Passed security stays passed until the next power-on reset
// - On mismatch protected reads return invalid data
// - Break sent after all eight security bytes arrived, or at once after a warm reset once security is done
// - Pass sets bit 6 of RAM location 60
// - NRZ signalling, equal transmit and receive rates
// - Wired-OR line: only pull low or release
// - Entry pins captured at reset release, then ignored
`include "mscl_regs.vh"
module mscl_link #(
    parameter [10:0] DIV_HIGH = `MSCL_DIV_HIGH,
    parameter [10:0] DIV_LOW = `MSCL_DIV_LOW
) (
    input wire core_clk_in,
    input wire rst_in,
    input wire por_in,
    input wire serial_line_pin_in,
    input wire baud_select_pin_in,
    input wire test_voltage_level_in,
    input wire [15:0] stack_pointer_in,
    input wire [7:0] mem_rdata_in,
    input wire mem_protected_in,
    output reg serial_line_pin_out,
    output reg serial_line_pin_oe_out,
    output reg [15:0] mem_addr_out,
    output reg [7:0] mem_wdata_out,
    output reg mem_rd_out,
    output reg mem_wr_out,
    output reg sec_ok_out,
    output reg run_out
);
// ---------------------------------------------------------------
// Synchronisers, entry capture
// ---------------------------------------------------------------
reg [1:0] rx_sync;
reg [10:0] div;
reg entry_done;
always @(posedge core_clk_in) begin
    rx_sync <= {rx_sync[0], serial_line_pin_in};
end
reg [1:0] bsel_sync;
reg [1:0] tst_sync;
always @(posedge core_clk_in) begin
    bsel_sync <= {bsel_sync[0], baud_select_pin_in};
    tst_sync <= {tst_sync[0], test_voltage_level_in};
end
always @(posedge core_clk_in) begin
    if (rst_in) begin
        entry_done <= 1'b0;
        div <= DIV_HIGH;
    end else if (!entry_done) begin
        entry_done <= 1'b1;
        if (tst_sync[1] && !bsel_sync[1])
            div <= DIV_LOW;
        else
            div <= DIV_HIGH;
    end
end
wire rx = rx_sync[1];
// ---------------------------------------------------------------
// Receiver: 10-bit frame, break detect
// ---------------------------------------------------------------
reg [10:0] rx_cnt;
reg [3:0] rx_bit;
reg rx_busy;
reg [8:0] rx_sh;
reg rx_any_high;
reg rx_done;
reg rx_brk;
always @(posedge core_clk_in) begin
    rx_done <= 1'b0;
    rx_brk <= 1'b0;
    if (rst_in) begin
        rx_busy <= 1'b0;
        rx_cnt <= 11'h000;
        rx_bit <= 4'h0;
        rx_sh <= 9'h000;
        rx_any_high <= 1'b0;
    end else if (!rx_busy) begin
        if (!rx && !tx_busy && !serial_line_pin_oe_out) begin
            rx_busy <= 1'b1;
            rx_cnt <= {1'b0, div[10:1]};
            rx_bit <= 4'h0;
            rx_any_high <= 1'b0;
        end
    end else if (rx_cnt == 11'h000) begin
        rx_cnt <= div - 11'h001;
        rx_sh <= {rx, rx_sh[8:1]};
        if (rx)
            rx_any_high <= 1'b1;
        if (rx_bit == 4'h9) begin
            rx_busy <= 1'b0;
            if (!rx && !rx_any_high)
                rx_brk <= 1'b1;
            else if (rx)
                rx_done <= 1'b1;
        end
        rx_bit <= rx_bit + 4'h1;
    end else begin
        rx_cnt <= rx_cnt - 11'h001;
    end
end
wire [7:0] rx_byte = rx_sh[7:0];
// ---------------------------------------------------------------
// Transmitter: gap, then frame or break
// ---------------------------------------------------------------
reg tx_go;
reg tx_brk_req;
reg [7:0] tx_data;
reg [3:0] tx_gap;
reg tx_busy;
reg [10:0] tx_cnt;
reg [3:0] tx_bit;
reg [9:0] tx_sh;
reg tx_in_gap;
always @(posedge core_clk_in) begin
    if (rst_in) begin
        tx_busy <= 1'b0;
        tx_in_gap <= 1'b0;
        tx_cnt <= 11'h000;
        tx_bit <= 4'h0;
        tx_sh <= 10'h3FF;
        serial_line_pin_out <= 1'b1;
        serial_line_pin_oe_out <= 1'b0;
    end else if (!tx_busy) begin
        if (tx_go) begin
            tx_busy <= 1'b1;
            tx_in_gap <= 1'b1;
            tx_bit <= tx_gap;
            tx_cnt <= div - 11'h001;
            tx_sh <= tx_brk_req ? 10'h000 : {1'b1, tx_data, 1'b0};
            serial_line_pin_out <= 1'b1;
            serial_line_pin_oe_out <= 1'b0;
        end
    end else if (tx_cnt != 11'h000) begin
        tx_cnt <= tx_cnt - 11'h001;
    end else begin
        tx_cnt <= div - 11'h001;
        if (tx_in_gap && tx_bit > 4'h1) begin
            tx_bit <= tx_bit - 4'h1;
        end else if (tx_in_gap) begin
            tx_in_gap <= 1'b0;
            tx_bit <= `MSCL_BREAK_BITS;
            serial_line_pin_out <= tx_sh[0];
            serial_line_pin_oe_out <= ~tx_sh[0];
            tx_sh <= {1'b1, tx_sh[9:1]};
        end else if (tx_bit > 4'h1) begin
            tx_bit <= tx_bit - 4'h1;
            serial_line_pin_out <= tx_sh[0];
            serial_line_pin_oe_out <= ~tx_sh[0];
            tx_sh <= {1'b1, tx_sh[9:1]};
        end else begin
            tx_busy <= 1'b0;
            serial_line_pin_out <= 1'b1;
            serial_line_pin_oe_out <= 1'b0;
        end
    end
end
// ---------------------------------------------------------------
// Command sequencer
// ---------------------------------------------------------------
localparam S_SEC = 3'h0;
localparam S_OP = 3'h1;
localparam S_ARG = 3'h2;
localparam S_EWAIT = 3'h3;
localparam S_RDATA = 3'h4;
localparam S_END = 3'h5;
localparam S_BRK = 3'h6;
reg [2:0] state;
reg [7:0] op;
reg [2:0] nargs;
reg [2:0] nrd;
reg [3:0] sec_idx;
reg sec_match;
reg sec_done;
reg [15:0] idx;
reg [15:0] wait_cnt;
reg [7:0] rd_shadow;
reg rd_q;
function [2:0] mscl_args;
    input [7:0] o;
    begin
        case (o)
            `MSCL_OP_READ: mscl_args = 3'h2;
            `MSCL_OP_WRITE: mscl_args = 3'h3;
            `MSCL_OP_INDEXED_WRITE_CMD: mscl_args = 3'h1;
            default: mscl_args = 3'h0;
        endcase
    end
endfunction
function mscl_known;
    input [7:0] o;
    begin
        mscl_known = (o == `MSCL_OP_READ) || (o == `MSCL_OP_WRITE) ||
            (o == `MSCL_OP_INDEXED_READ_CMD) || (o == `MSCL_OP_INDEXED_WRITE_CMD) ||
            (o == `MSCL_OP_STACK_POINTER_READ_CMD) || (o == `MSCL_OP_RUN);
    end
endfunction
always @(posedge core_clk_in) begin
    tx_go <= 1'b0;
    mem_rd_out <= 1'b0;
    mem_wr_out <= 1'b0;
    run_out <= 1'b0;
    rd_q <= mem_rd_out;
    if (por_in) begin
        sec_done <= 1'b0;
        sec_ok_out <= 1'b0;
    end
    if (rst_in) begin
        state <= S_SEC;
        op <= 8'h00;
        nargs <= 3'h0;
        nrd <= 3'h0;
        sec_idx <= 4'h0;
        sec_match <= 1'b1;
        idx <= 16'h0000;
        wait_cnt <= 16'h0000;
        tx_brk_req <= 1'b0;
        tx_data <= 8'h00;
        tx_gap <= `MSCL_PRE_GAP_BITS;
        mem_addr_out <= 16'h0000;
        mem_wdata_out <= 8'h00;
        rd_shadow <= 8'h00;
    end else if (entry_done) begin
        case (state)
            S_SEC: begin
                if (sec_done) begin
                    state <= S_BRK;
                end else if (rx_done && sec_idx < `MSCL_SEC_BYTES) begin
                    tx_go <= 1'b1;
                    tx_brk_req <= 1'b0;
                    tx_data <= rx_byte;
                    mem_addr_out <= `MSCL_SEC_BASE + {12'h000, sec_idx};
                    mem_rd_out <= 1'b1;
                    rd_shadow <= rx_byte;
                    sec_idx <= sec_idx + 4'h1;
                end else if (rd_q) begin
                    if (mem_rdata_in != rd_shadow)
                        sec_match <= 1'b0;
                end else if (sec_idx == `MSCL_SEC_BYTES && !tx_busy &&
                    !tx_go) begin
                    sec_done <= 1'b1;
                    sec_ok_out <= sec_match;
                    if (sec_match) begin
                        mem_addr_out <= `MSCL_SEC_FLAG_ADDR;
                        mem_wdata_out <= 8'h40;
                        mem_wr_out <= 1'b1;
                    end
                    state <= S_BRK;
                end
            end
            S_BRK: begin
                if (!tx_busy && !tx_go) begin
                    tx_go <= 1'b1;
                    tx_brk_req <= 1'b1;
                    state <= S_EWAIT;
                end
            end
            S_OP: begin
                if (rx_brk) begin
                    state <= S_BRK;
                end else if (rx_done) begin
                    tx_go <= 1'b1;
                    tx_brk_req <= 1'b0;
                    tx_data <= rx_byte;
                    op <= rx_byte;
                    nargs <= mscl_args(rx_byte);
                    state <= !mscl_known(rx_byte) ? S_OP :
                        (mscl_args(rx_byte) != 3'h0) ? S_ARG : S_EWAIT;
                end
            end
            S_ARG: begin
                if (rx_brk) begin
                    state <= S_BRK;
                end else if (rx_done) begin
                    tx_go <= 1'b1;
                    tx_brk_req <= 1'b0;
                    tx_data <= rx_byte;
                    nargs <= nargs - 3'h1;
                    if (op == `MSCL_OP_INDEXED_WRITE_CMD ||
                        (op == `MSCL_OP_WRITE && nargs == 3'h1))
                        mem_wdata_out <= rx_byte;
                    else
                        idx <= {idx[7:0], rx_byte};
                    if (nargs == 3'h1)
                        state <= S_EWAIT;
                end
            end
            S_EWAIT: begin
                if (!tx_busy && !tx_go) begin
                    state <= S_END;
                    wait_cnt <= {5'h00, div} * {12'h000, `MSCL_END_WAIT_BITS};
                    nrd <= 3'h0;
                    case (op)
                        `MSCL_OP_READ: begin
                            nrd <= 3'h1;
                            mem_addr_out <= idx;
                            mem_rd_out <= 1'b1;
                        end
                        `MSCL_OP_INDEXED_READ_CMD: begin
                            nrd <= 3'h2;
                            mem_addr_out <= idx + 16'h0001;
                            idx <= idx + 16'h0001;
                            mem_rd_out <= 1'b1;
                        end
                        `MSCL_OP_STACK_POINTER_READ_CMD: begin
                            nrd <= 3'h2;
                            idx <= stack_pointer_in + `MSCL_SP_PLUS;
                        end
                        `MSCL_OP_WRITE: begin
                            mem_addr_out <= idx;
                            mem_wr_out <= 1'b1;
                        end
                        `MSCL_OP_INDEXED_WRITE_CMD: begin
                            idx <= idx + 16'h0001;
                            mem_addr_out <= idx + 16'h0001;
                            mem_wr_out <= 1'b1;
                        end
                        `MSCL_OP_RUN: run_out <= 1'b1;
                        default: nrd <= 3'h0;
                    endcase
                    if (op == `MSCL_OP_READ || op == `MSCL_OP_INDEXED_READ_CMD ||
                        op == `MSCL_OP_STACK_POINTER_READ_CMD)
                        state <= S_RDATA;
                end
            end
            S_RDATA: begin
                if (!tx_busy && !tx_go && !mem_rd_out) begin
                    tx_go <= 1'b1;
                    tx_brk_req <= 1'b0;
                    if (op == `MSCL_OP_STACK_POINTER_READ_CMD)
                        tx_data <= (nrd == 3'h2) ? idx[15:8] : idx[7:0];
                    else if (mem_protected_in && !sec_ok_out)
                        tx_data <= 8'hAD;
                    else
                        tx_data <= mem_rdata_in;
                    nrd <= nrd - 3'h1;
                    if (nrd == 3'h2 && op == `MSCL_OP_INDEXED_READ_CMD) begin
                        mem_addr_out <= idx + 16'h0001;
                        idx <= idx + 16'h0001;
                        mem_rd_out <= 1'b1;
                    end
                    if (nrd == 3'h1) begin
                        state <= S_END;
                        wait_cnt <= {5'h00, div} *
                            {12'h000, `MSCL_END_WAIT_BITS};
                    end
                end
            end
            S_END: begin
                if (rx_brk)
                    state <= S_BRK;
                else if (tx_busy || tx_go)
                    wait_cnt <= wait_cnt;
                else if (wait_cnt == 16'h0000)
                    state <= S_OP;
                else
                    wait_cnt <= wait_cnt - 16'h0001;
            end
            default: state <= S_OP;
        endcase
    end
end
endmodule // mscl_link

/* File: verif/mscl_link_chk.sv */
// Assertion checker for the monitor serial command link
module mscl_link_chk #(parameter int BT = 512, parameter int BT_MAX = 1024) (
    input logic core_clk_in,
    input logic rst_in,
    input logic por_in,
    input logic serial_line_pin_in,
    input logic serial_line_pin_out,
    input logic serial_line_pin_oe_out,
    input logic mem_rd_out,
    input logic mem_wr_out,
    input logic sec_ok_out,
    input logic run_out
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MAXLOW = 10 * BT_MAX;
    logic oe_q;
    logic [15:0] run_cnt;
    logic [15:0] hi_cnt;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    always @(posedge core_clk_in) begin
        oe_q <= serial_line_pin_oe_out;
        if (rst_in || serial_line_pin_oe_out != oe_q) begin
            run_cnt <= 16'h0000;
        end else begin
            run_cnt <= run_cnt + 16'h0001;
        end
        if (rst_in) begin
            hi_cnt <= 16'hFFFF;
        end else if (!serial_line_pin_in) begin
            hi_cnt <= 16'h0000;
        end else if (hi_cnt != 16'hFFFF) begin
            hi_cnt <= hi_cnt + 16'h0001;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_pull_low_only: assert property (
        serial_line_pin_oe_out |-> !serial_line_pin_out)
        else $error("line driven high");
    a_reset_release: assert property (disable iff (1'b0)
        rst_in |=> !serial_line_pin_oe_out && !mem_rd_out && !mem_wr_out
        && !run_out) else $error("outputs active in reset");
    a_low_run_len: assert property (
        $fell(serial_line_pin_oe_out) |->
        (int'(run_cnt) + 1) % BT == 0 && int'(run_cnt) < MAXLOW)
        else $error("low run not whole bits");
    a_echo_gap: assert property (
        $rose(serial_line_pin_oe_out) |-> int'(hi_cnt) >= BT)
        else $error("gap before transmit too short");
    a_sec_kept: assert property (disable iff (por_in)
        sec_ok_out |=> sec_ok_out) else $error("security lost");
    a_rd_pulse: assert property (
        mem_rd_out |=> !mem_rd_out) else $error("read pulse long");
    a_wr_pulse: assert property (
        mem_wr_out |=> !mem_wr_out) else $error("write pulse long");
    a_run_pulse: assert property (
        run_out |=> !run_out) else $error("run pulse long");
    c_sec: cover property ($rose(sec_ok_out));
    c_read: cover property (mem_rd_out);
    c_run: cover property (run_out);
endmodule // mscl_link_chk

/* File: verif/mscl_host_model.sv */
// Host-side serial model for the monitor command link
module mscl_host_model (
    input logic clk_in,
    input logic line_in,
    output logic low_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int bt = 512;
    initial begin
        low_out = 1'b0;
    end
    // ------------------------------------------------------------
    // Send one frame, only pulling low
    // ------------------------------------------------------------
    task automatic tx(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        @(posedge clk_in);
        for (int i = 0; i < 10; i++) begin
            low_out <= ~f[i];
            repeat (bt) @(posedge clk_in);
        end
    endtask
    // ------------------------------------------------------------
    // Receive one frame, measuring the first low run
    // ------------------------------------------------------------
    task automatic rx(output logic [7:0] d, output int lo);
        int n;
        bit run;
        n = 0;
        run = 1'b1;
        lo = 0;
        d = 8'h00;
        while (line_in !== 1'b0 && n < 40 * bt) begin
            @(negedge clk_in);
            n++;
        end
        for (int k = 0; k < 10 * bt; k++) begin
            if (k > bt && k < 9 * bt && k % bt == bt / 2) begin
                d[k / bt - 1] = line_in;
            end
            if (line_in !== 1'b0) begin
                run = 1'b0;
            end
            if (run) begin
                lo++;
            end
            @(negedge clk_in);
        end
        while (line_in === 1'b0 && lo < 12 * bt) begin
            lo++;
            @(negedge clk_in);
        end
    endtask
endmodule // mscl_host_model

/* File: verif/mscl_link_bench.sv */
// Self-checking bench for the monitor serial command link
module mscl_link_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BT_LO = 32;
    localparam int BT_HI = 64;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic por_in = 1'b1;
    logic baud_select_pin_in = 1'b0;
    logic test_voltage_level_in = 1'b1;
    logic [15:0] stack_pointer_in = 16'h01F0;
    logic [7:0] mem_rdata_in = 8'h00;
    logic mem_protected_in = 1'b0;
    logic serial_line_pin_out;
    logic serial_line_pin_oe_out;
    logic [15:0] mem_addr_out;
    logic [7:0] mem_wdata_out;
    logic mem_rd_out;
    logic mem_wr_out;
    logic sec_ok_out;
    logic run_out;
    logic host_low;
    logic [7:0] flag = 8'h00;
    logic saw_run = 1'b0;
    logic [15:0] wr_addr = 16'h0000;
    logic [7:0] wr_data = 8'h00;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    // Wired-OR line with pull-up
    wire serial_line_pin_in = !(serial_line_pin_oe_out
        && !serial_line_pin_out) && !host_low;
    mscl_link #(.DIV_HIGH(11'h040), .DIV_LOW(11'h020)) mscl_link_inst (.*);
    mscl_host_model mscl_host_model_inst (.clk_in(core_clk_in),
        .line_in(serial_line_pin_in), .low_out(host_low));
    initial begin
        forever #20 core_clk_in = ~core_clk_in;
    end
    // ------------------------------------------------------------
    // Memory model and timeout
    // ------------------------------------------------------------
    always @(posedge core_clk_in) begin
        mem_rdata_in <= mem_addr_out[7:0] ^ 8'hC3;
        if (mem_wr_out && mem_addr_out == 16'h0060) begin
            flag <= mem_wdata_out;
        end
        if (run_out) begin
            saw_run <= 1'b1;
        end
        if (mem_wr_out) begin
            wr_addr <= mem_addr_out;
            wr_data <= mem_wdata_out;
        end
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_fail++;
            test_done;
        end
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xb(input logic [7:0] b);
        logic [7:0] e;
        int lo;
        mscl_host_model_inst.tx(b);
        mscl_host_model_inst.rx(e, lo);
        check("echo", {8'h00, b}, {8'h00, e});
        repeat (2 * mscl_host_model_inst.bt) @(posedge core_clk_in);
    endtask
    task automatic t_security;
        logic [7:0] e;
        int lo;
        for (int i = 0; i < 8; i++) begin
            xb((8'hF6 + 8'(i)) ^ 8'hC3);
        end
        mscl_host_model_inst.rx(e, lo);
        check("ready break", 16'(10 * BT_LO), 16'(lo));
        check("security ok", 16'h0001, {15'h0, sec_ok_out});
        check("ram flag", 16'h0001, {15'h0, flag[6]});
        $display("security test done");
    endtask
    task automatic t_cmds;
        logic [7:0] e;
        int lo;
        repeat (12 * BT_LO) @(posedge core_clk_in);
        xb(8'h4A);
        xb(8'h12);
        mscl_host_model_inst.tx(8'h34);
        mscl_host_model_inst.rx(e, lo);
        check("last echo", 16'h0034, {8'h00, e});
        mscl_host_model_inst.rx(e, lo);
        check("read data", 16'h00F7, {8'h00, e});
        repeat (12 * BT_LO) @(posedge core_clk_in);
        xb(8'h49);
        xb(8'hAB);
        xb(8'hCD);
        xb(8'h5A);
        repeat (12 * BT_LO) @(posedge core_clk_in);
        check("write addr", 16'hABCD, wr_addr);
        check("write data", 16'h005A, {8'h00, wr_data});
        mscl_host_model_inst.tx(8'h0C);
        mscl_host_model_inst.rx(e, lo);
        check("stack_pointer_read_cmd echo", 16'h000C, {8'h00, e});
        mscl_host_model_inst.rx(e, lo);
        check("sp high", 16'h0001, {8'h00, e});
        mscl_host_model_inst.rx(e, lo);
        check("sp low", 16'h00F1, {8'h00, e});
        repeat (12 * BT_LO) @(posedge core_clk_in);
        xb(8'h28);
        check("run pulse", 16'h0001, {15'h0, saw_run});
        repeat (12 * BT_LO) @(posedge core_clk_in);
        $display("command test done");
    endtask
    task automatic t_warm(input logic tv, input logic bd, input int div);
        logic [7:0] e;
        int lo;
        @(posedge core_clk_in);
        test_voltage_level_in <= tv;
        baud_select_pin_in <= bd;
        rst_in <= 1'b1;
        repeat (6) @(posedge core_clk_in);
        rst_in <= 1'b0;
        mscl_host_model_inst.bt = div;
        fork
            mscl_host_model_inst.rx(e, lo);
            begin
                repeat (4) @(posedge core_clk_in);
                test_voltage_level_in <= ~tv;
                baud_select_pin_in <= ~bd;
            end
        join
        check("break length", 16'(10 * div), 16'(lo));
        check("security kept", 16'h0001, {15'h0, sec_ok_out});
        $display("warm reset test done");
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        mscl_host_model_inst.bt = BT_LO;
        repeat (6) @(posedge core_clk_in);
        rst_in <= 1'b0;
        por_in <= 1'b0;
        repeat (8) @(posedge core_clk_in);
        t_security;
        t_cmds;
        t_warm(1'b0, 1'b0, BT_HI);
        t_warm(1'b1, 1'b1, BT_HI);
        test_done;
    end
endmodule // mscl_link_bench
bind mscl_link mscl_link_chk #(.BT(32), .BT_MAX(64)) mscl_link_chk_inst (.*);
